// file: logic/dpsem_params.svh
// Constants for the host controller of one dual-port RAM port.
`ifndef DPSEM_PARAMS_SVH
`define DPSEM_PARAMS_SVH

`define CLK_PERIOD_NS                10
`define SETUP_NS                     10
`define WRITE_PULSE_NS               20
`define READ_ACCESS_NS               20
`define RECOVER_NS                   10
`define FLAG_RELEASE_GAP_NS          10
`define FLAG_WRITE_TO_READ_DELAY_NS  10
`define DRIVE_ENABLE_ACCESS_DELAY_NS 10

`define NS2CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYC   (8'(`NS2CYC(`SETUP_NS)))
`define WRITE_CYC   (8'(`NS2CYC(`WRITE_PULSE_NS)))
`define READ_CYC    (8'(`NS2CYC(`READ_ACCESS_NS)))
`define RECOVER_CYC (8'(`NS2CYC(`RECOVER_NS)))
`define FLAG_GAP_CYC (8'( \
   (`FLAG_RELEASE_GAP_NS > `FLAG_WRITE_TO_READ_DELAY_NS) \
   ? `NS2CYC(`FLAG_RELEASE_GAP_NS) : `NS2CYC(`FLAG_WRITE_TO_READ_DELAY_NS)))
`define FLAG_READ_CYC (8'(`NS2CYC(`DRIVE_ENABLE_ACCESS_DELAY_NS)))

`define MBX_TOP_ADDR  16'hFFFF
`define MBX_NEXT_ADDR 16'hFFFE
`define FLAG_IDX_MASK 16'h0007
`define ADDR_W        16
`define DATA_W        18
`define LOW_LANE_HI   8
`define HIGH_LANE_LO  9

`endif

// file: logic/dpsem_pkg.sv
// Types shared by the dual-port RAM port host controller.
package dpsem_pkg;
   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_SETUP = 6'h02,
      ST_WR    = 6'h04,
      ST_GAP   = 6'h08,
      ST_RD    = 6'h10,
      ST_DONE  = 6'h20
   } phase_t;

   typedef enum logic [2:0] {
      OP_READ      = 3'h0,
      OP_WRITE     = 3'h1,
      OP_SEM_TAKE  = 3'h2,
      OP_SEM_GIVE  = 3'h3,
      OP_SEM_PEEK  = 3'h4,
      OP_MBX_SEND  = 3'h5,
      OP_MBX_FETCH = 3'h6
   } op_t;

   typedef struct packed {
      op_t         op;
      logic [15:0] addr;
      logic [17:0] wdata;
      logic [1:0]  byte_en;
   } req_t;

   typedef struct packed {
      logic [17:0] rdata;
      logic        owned;
   } resp_t;

   typedef struct packed {
      logic        ce_n;
      logic        rw_n;
      logic        oe_n;
      logic        sem_n;
      logic        high_byte_sel_n;
      logic        low_byte_sel_n;
      logic [15:0] addr;
      logic [17:0] dout;
      logic        dq_oe;
   } pins_t;

   typedef struct packed {
      phase_t phase;
      req_t   req;
      pins_t  pins;
      resp_t  resp;
      logic   mail_pending;
   } host_state_t;

   typedef struct packed {
      logic [7:0] count;
   } timer_state_t;
endpackage

// file: logic/port_strobe_timer.sv
// Down counter that times each phase of a port access.
`timescale 1ns/100ps
module port_strobe_timer (
   input  wire logic       sys_clk,  // System clock.
   input  wire logic       rst_n,    // Asynchronous reset, active low.
   input  wire logic       clk_en,   // Freezes the count while low.
   input  wire logic       load,     // Restart the count.
   input  wire logic [7:0] load_val, // Cycles to count.
   output logic            expired   // Count has reached zero.
);
   dpsem_pkg::timer_state_t cur;
   dpsem_pkg::timer_state_t next_cur;

   always_comb begin
      next_cur = cur;
      if (load) begin
         next_cur.count = load_val;
      end else if (cur.count != 8'h00) begin
         next_cur.count = cur.count - 8'h01;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
      end else if (clk_en) begin
         cur <= next_cur;
      end
   end

   assign expired = (cur.count == 8'h00);
endmodule

// file: logic/dpsem_host.sv
// Host controller driving one port of an asynchronous dual-port RAM.
`timescale 1ns/100ps
`include "dpsem_params.svh"
module dpsem_host (
   input  wire logic             sys_clk,      // System clock, 100 MHz.
   input  wire logic             rst_n,        // Async reset, active low.
   input  wire logic             clk_en,       // Freezes all state if low.
   input  wire logic             is_left_port, // High when wired to left.
   input  wire logic             cmd_valid,    // Command offered.
   output logic                  cmd_ready,    // Command taken when high.
   input  wire dpsem_pkg::req_t  cmd,          // Command contents.
   input  wire logic             sem_abort,    // Cancel a flag poll.
   output logic                  resp_valid,   // One-cycle answer strobe.
   output dpsem_pkg::resp_t      resp,         // Answer contents.
   output logic                  mail_pending, // Own mailbox interrupt.
   output dpsem_pkg::pins_t      pins,         // Port control and data out.
   input  wire logic [17:0]      dq_in,        // Data pins as read.
   input  wire logic             int_n,        // Interrupt pin, active low.
   input  wire logic             busy_n        // Arbitration stall, low.
);
   dpsem_pkg::host_state_t cur;
   dpsem_pkg::host_state_t next_cur;
   logic                   tmr_load;
   logic [7:0]             tmr_val;
   logic                   tmr_done;
   logic                   flag_op;
   logic                   write_op;
   logic                   ram_op;

   port_strobe_timer u_timer (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .clk_en   (clk_en),
      .load     (tmr_load),
      .load_val (tmr_val),
      .expired  (tmr_done)
   );

   // Flag operations go through the flag select, never the chip enable.
   always_comb begin
      flag_op  = (cur.req.op == dpsem_pkg::OP_SEM_TAKE) ||
                 (cur.req.op == dpsem_pkg::OP_SEM_GIVE) ||
                 (cur.req.op == dpsem_pkg::OP_SEM_PEEK);
      write_op = (cur.req.op == dpsem_pkg::OP_WRITE) ||
                 (cur.req.op == dpsem_pkg::OP_MBX_SEND) ||
                 (cur.req.op == dpsem_pkg::OP_SEM_TAKE) ||
                 (cur.req.op == dpsem_pkg::OP_SEM_GIVE);
      ram_op   = !flag_op;
   end

   always_comb begin
      next_cur = cur;
      tmr_load = 1'b0;
      tmr_val  = 8'h00;
      // The interrupt pin is followed one cycle late and left to the user.
      next_cur.mail_pending = !int_n;
      unique case (cur.phase)
         dpsem_pkg::ST_IDLE: begin
            // Idle port is deselected so the device powers down.
            next_cur.pins.ce_n            = 1'b1;
            next_cur.pins.sem_n           = 1'b1;
            next_cur.pins.oe_n            = 1'b1;
            next_cur.pins.rw_n            = 1'b1;
            next_cur.pins.high_byte_sel_n = 1'b1;
            next_cur.pins.low_byte_sel_n  = 1'b1;
            next_cur.pins.dq_oe           = 1'b0;
            if (cmd_valid) begin
               next_cur.req   = cmd;
               next_cur.phase = dpsem_pkg::ST_SETUP;
               tmr_load = 1'b1;
               tmr_val  = `SETUP_CYC;
               unique case (cmd.op)
                  dpsem_pkg::OP_MBX_SEND: begin
                     next_cur.req.addr = is_left_port ?
                        `MBX_TOP_ADDR : `MBX_NEXT_ADDR;
                     next_cur.req.byte_en = 2'h3;
                  end
                  dpsem_pkg::OP_MBX_FETCH: begin
                     next_cur.req.addr = is_left_port ?
                        `MBX_NEXT_ADDR : `MBX_TOP_ADDR;
                     next_cur.req.byte_en = 2'h3;
                  end
                  dpsem_pkg::OP_SEM_TAKE, dpsem_pkg::OP_SEM_GIVE,
                  dpsem_pkg::OP_SEM_PEEK: begin
                     // Upper address bits are don't-care on the device.
                     next_cur.req.addr = cmd.addr & `FLAG_IDX_MASK;
                  end
                  default: begin
                  end
               endcase
               next_cur.pins.addr = next_cur.req.addr;
            end
         end
         dpsem_pkg::ST_SETUP: begin
            if (tmr_done) begin
               tmr_load = 1'b1;
               if (flag_op) begin
                  // Chip enable and byte selects stay high for flags.
                  next_cur.pins.sem_n = 1'b0;
               end else begin
                  next_cur.pins.ce_n            = 1'b0;
                  next_cur.pins.high_byte_sel_n = !cur.req.byte_en[1];
                  next_cur.pins.low_byte_sel_n  = !cur.req.byte_en[0];
               end
               if (write_op) begin
                  next_cur.phase      = dpsem_pkg::ST_WR;
                  next_cur.pins.rw_n  = 1'b0;
                  next_cur.pins.dq_oe = 1'b1;
                  tmr_val = `WRITE_CYC;
                  if (cur.req.op == dpsem_pkg::OP_SEM_TAKE) begin
                     next_cur.pins.dout = '0;
                  end else if (cur.req.op == dpsem_pkg::OP_SEM_GIVE) begin
                     next_cur.pins.dout = '1;
                  end else begin
                     next_cur.pins.dout = cur.req.wdata;
                  end
               end else begin
                  next_cur.phase     = dpsem_pkg::ST_RD;
                  next_cur.pins.oe_n = 1'b0;
                  tmr_val = flag_op ? `FLAG_READ_CYC : `READ_CYC;
               end
            end
         end
         dpsem_pkg::ST_WR: begin
            // A stalled port's mailbox write would be dropped, so hold on.
            if (ram_op && !busy_n) begin
               tmr_load = 1'b1;
               tmr_val  = `WRITE_CYC;
            end else if (tmr_done) begin
               next_cur.phase      = dpsem_pkg::ST_GAP;
               next_cur.pins.rw_n  = 1'b1;
               next_cur.pins.sem_n = 1'b1;
               next_cur.pins.ce_n  = 1'b1;
               next_cur.pins.high_byte_sel_n = 1'b1;
               next_cur.pins.low_byte_sel_n  = 1'b1;
               next_cur.pins.dq_oe = 1'b0;
               tmr_load = 1'b1;
               tmr_val  = (cur.req.op == dpsem_pkg::OP_SEM_TAKE) ?
                          `FLAG_GAP_CYC : `RECOVER_CYC;
            end
         end
         dpsem_pkg::ST_GAP: begin
            if (tmr_done) begin
               if (cur.req.op == dpsem_pkg::OP_SEM_TAKE) begin
                  next_cur.phase      = dpsem_pkg::ST_RD;
                  next_cur.pins.sem_n = 1'b0;
                  next_cur.pins.oe_n  = 1'b0;
                  tmr_load = 1'b1;
                  tmr_val  = `FLAG_READ_CYC;
               end else begin
                  next_cur.phase = dpsem_pkg::ST_DONE;
               end
            end
         end
         dpsem_pkg::ST_RD: begin
            // A stalled port cannot clear its interrupt; wait for release.
            if (ram_op && !busy_n) begin
               tmr_load = 1'b1;
               tmr_val  = `READ_CYC;
            end else if (tmr_done) begin
               next_cur.resp.rdata = dq_in;
               next_cur.resp.owned = 1'b0;
               next_cur.pins.oe_n  = 1'b1;
               next_cur.pins.sem_n = 1'b1;
               next_cur.pins.ce_n  = 1'b1;
               next_cur.pins.high_byte_sel_n = 1'b1;
               next_cur.pins.low_byte_sel_n  = 1'b1;
               tmr_load = 1'b1;
               tmr_val  = `RECOVER_CYC;
               if (cur.req.op == dpsem_pkg::OP_SEM_TAKE) begin
                  if (!dq_in[0]) begin
                     next_cur.resp.owned = 1'b1;
                     next_cur.phase      = dpsem_pkg::ST_GAP;
                     next_cur.req.op     = dpsem_pkg::OP_SEM_PEEK;
                  end else if (sem_abort) begin
                     // Withdraw the pending request so it cannot be granted.
                     next_cur.req.op = dpsem_pkg::OP_SEM_GIVE;
                     next_cur.phase  = dpsem_pkg::ST_SETUP;
                     tmr_val = `FLAG_GAP_CYC;
                  end else begin
                     next_cur.phase = dpsem_pkg::ST_GAP;
                     tmr_val = `FLAG_GAP_CYC;
                  end
               end else begin
                  next_cur.phase = dpsem_pkg::ST_GAP;
               end
            end
         end
         dpsem_pkg::ST_DONE: begin
            // The answer strobe stands for this one cycle only.
            next_cur.phase = dpsem_pkg::ST_IDLE;
         end
      endcase
   end

   // Reset parks every strobe high so the device sits powered down.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
         cur.phase <= dpsem_pkg::ST_IDLE;
         cur.pins.ce_n <= 1'b1;
         cur.pins.rw_n <= 1'b1;
         cur.pins.oe_n <= 1'b1;
         cur.pins.sem_n <= 1'b1;
         cur.pins.high_byte_sel_n <= 1'b1;
         cur.pins.low_byte_sel_n <= 1'b1;
      end else if (clk_en) begin
         cur <= next_cur;
      end
   end

   // Handshake outputs decode the phase; the pins come straight from flops.
   assign cmd_ready    = (cur.phase == dpsem_pkg::ST_IDLE);
   assign resp_valid   = (cur.phase == dpsem_pkg::ST_DONE);
   assign resp         = cur.resp;
   assign mail_pending = cur.mail_pending;
   assign pins         = cur.pins;
endmodule

// file: test/dpsem_host_checker.sv
// Port-level assertions for the dual-port RAM host controller.
`timescale 1ns/100ps
module dpsem_host_checker (
   input wire logic             sys_clk,    // Clock.
   input wire logic             rst_n,      // Reset, active low.
   input wire logic             clk_en,     // Run enable.
   input wire logic             cmd_valid,  // Command offered.
   input wire logic             cmd_ready,  // Command can be taken.
   input wire dpsem_pkg::req_t  cmd,        // Command contents.
   input wire logic             resp_valid, // Answer strobe.
   input wire dpsem_pkg::resp_t resp,       // Answer contents.
   input wire dpsem_pkg::pins_t pins        // Port pins.
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire take = cmd_valid && cmd_ready && clk_en;
   wire lanes_off = pins.high_byte_sel_n && pins.low_byte_sel_n;
   a_flag_chip_sel: assert property (!pins.sem_n |-> pins.ce_n)
      else $error("flag select with chip enable low");
   a_flag_legal_mix: assert property (
      (!pins.ce_n && !lanes_off) |-> pins.sem_n)
      else $error("forbidden select mix");
   a_read_direction: assert property (!pins.oe_n |->
      (pins.rw_n && !pins.dq_oe)) else $error("drive clash on read");
   a_write_drive: assert property (
      (!pins.rw_n && !pins.ce_n) |-> pins.dq_oe)
      else $error("write without data drive");
   a_flag_release_gap: assert property (($rose(pins.sem_n) &&
      !$past(pins.rw_n)) |-> pins.sem_n[*2])
      else $error("flag read-back too soon");
   a_flag_write_word: assert property (
      (!pins.sem_n && !pins.rw_n) |-> (pins.dout == {18{pins.dout[0]}}))
      else $error("flag write word not uniform");
   a_select_lane: assert property (!pins.ce_n |-> !lanes_off)
      else $error("selected with no byte lane");
   a_write_done: assert property ((take &&
      cmd.op == dpsem_pkg::OP_WRITE) |-> ##[4:16] resp_valid)
      else $error("write answer late");
   c_granted: cover property (resp_valid && resp.owned);
   c_flag_read: cover property (!pins.sem_n && !pins.oe_n);
   c_ram_write: cover property (!pins.ce_n && !pins.rw_n);
endmodule

// file: test/dpsem_ram_model.sv
// Behavioural dual-port RAM: left port on pins, right port from the bench.
`timescale 1ns/100ps
module dpsem_ram_model (
   input  wire dpsem_pkg::pins_t pins,    // Left port pins.
   input  wire logic             sys_clk, // Clock.
   output logic [17:0]           dq_in,   // Left data pins.
   output logic                  int_n,   // Left interrupt.
   output logic                  int_r_n, // Right interrupt.
   input  wire logic             r_wr,    // Right flag write.
   input  wire logic [2:0]       r_idx,   // Right flag index.
   input  wire logic             r_bit,   // Right written value.
   input  wire logic             r_mail,  // Right writes left mailbox.
   input  wire logic             r_fetch, // Right reads own mailbox.
   input  wire logic             stall_n  // Left arbitration stall.
);
   logic [17:0] mem [0:15];
   logic [7:0]  h_own = 0, o_own = 0, h_pend = 0, o_pend = 0;
   logic        hold = 1, tog = 0;
   wire flag = !pins.sem_n;
   wire ram = !pins.ce_n && pins.sem_n;
   wire [2:0] fi = pins.addr[2:0];
   wire [3:0] ai = pins.addr[3:0];
   wire h_claim = flag && !pins.rw_n && !pins.dout[0] && fi == r_idx;
   initial begin
      int_n = 1;
      int_r_n = 1;
   end
   // Floating lanes toggle so a stale value can never look correct.
   always_comb begin
      dq_in = {9{tog, ~tog}};
      if (!pins.oe_n && pins.rw_n) begin
         if (flag) dq_in = {18{hold}};
         else if (ram) begin
            if (!pins.high_byte_sel_n) dq_in[17:9] = mem[ai][17:9];
            if (!pins.low_byte_sel_n) dq_in[8:0] = mem[ai][8:0];
         end
      end
   end
   always @(posedge sys_clk) begin
      tog <= ~tog;
      if (!(flag && !pins.oe_n)) hold <= ~h_own[fi];
      if (flag && !pins.rw_n) begin
         if (!pins.dout[0]) begin
            if (!o_own[fi]) h_own[fi] <= 1'b1;
            else h_pend[fi] <= 1'b1;
         end else if (h_own[fi]) begin
            h_own[fi] <= 1'b0;
            o_own[fi] <= o_pend[fi];
            o_pend[fi] <= 1'b0;
         end else h_pend[fi] <= 1'b0;
      end
      if (r_wr) begin
         if (!r_bit) begin
            // Same-cycle claims on a free flag: the host side wins.
            if (!h_own[r_idx] && !(h_claim && !o_own[r_idx]))
               o_own[r_idx] <= 1'b1;
            else o_pend[r_idx] <= 1'b1;
         end else if (o_own[r_idx]) begin
            o_own[r_idx] <= 1'b0;
            h_own[r_idx] <= h_pend[r_idx];
            h_pend[r_idx] <= 1'b0;
         end else o_pend[r_idx] <= 1'b0;
      end
      if (ram && !pins.rw_n) begin
         if (!pins.high_byte_sel_n) mem[ai][17:9] <= pins.dout[17:9];
         if (!pins.low_byte_sel_n) mem[ai][8:0] <= pins.dout[8:0];
         if (pins.addr == 16'hFFFF && stall_n) int_r_n <= 1'b0;
      end
      if (ram && pins.rw_n && !pins.oe_n && stall_n &&
          pins.addr == 16'hFFFE) int_n <= 1'b1;
      if (r_mail) int_n <= 1'b0;
      if (r_fetch) int_r_n <= 1'b1;
   end
endmodule

// file: test/dual_port_semaphore_mailbox_test.sv
// Self-checking bench for the dual-port RAM host controller.
`timescale 1ns/100ps
module dual_port_semaphore_mailbox_test;
   typedef struct {
      dpsem_pkg::op_t op;
      logic [15:0]    a;
      logic [17:0]    d;
      logic [1:0]     be;
      logic [17:0]    m;
      logic [17:0]    e;
   } row_t;
   logic sys_clk = 0, rst_n = 0, cmd_valid = 0, sem_abort = 0;
   logic r_wr = 0, r_bit = 1, r_mail = 0, r_fetch = 0, busy_n = 1;
   logic is_left_port = 1, clk_en = 1;
   logic [2:0] r_idx = 0;
   dpsem_pkg::req_t cmd = '0;
   logic cmd_ready, resp_valid, mail_pending, int_n, int_r_n;
   dpsem_pkg::resp_t resp;
   dpsem_pkg::pins_t pins;
   dpsem_pkg::pins_t p;
   logic [17:0] dq_in;
   int n_mismatch = 0, compares = 0;
   // Upper-only write then per-lane reads; high address bits on flags.
   row_t rows[10] = '{
      '{dpsem_pkg::OP_WRITE, 16'h0003, 18'h2ABCD, 2'h3, 18'h0, 18'h0},
      '{dpsem_pkg::OP_READ, 16'h0003, 18'h0, 2'h3, 18'h3FFFF, 18'h2ABCD},
      '{dpsem_pkg::OP_WRITE, 16'h0003, 18'h15555, 2'h2, 18'h0, 18'h0},
      '{dpsem_pkg::OP_READ, 16'h0003, 18'h0, 2'h1, 18'h001FF, 18'h001CD},
      '{dpsem_pkg::OP_READ, 16'h0003, 18'h0, 2'h2, 18'h3FE00, 18'h15400},
      '{dpsem_pkg::OP_SEM_TAKE, 16'hFFF5, 18'h0, 2'h3, 18'h0, 18'h0},
      '{dpsem_pkg::OP_SEM_PEEK, 16'h0005, 18'h0, 2'h3, 18'h3FFFF, 18'h0},
      '{dpsem_pkg::OP_SEM_GIVE, 16'h0005, 18'h0, 2'h3, 18'h0, 18'h0},
      '{dpsem_pkg::OP_SEM_PEEK, 16'h000D, 18'h0, 2'h3, 18'h3FFFF,
        18'h3FFFF},
      '{dpsem_pkg::OP_MBX_SEND, 16'h0000, 18'h01234, 2'h3, 18'h0, 18'h0}};
   always #5 sys_clk = ~sys_clk;
   dpsem_host u_dut (.sys_clk, .rst_n, .clk_en, .is_left_port,
      .cmd_valid, .cmd_ready, .cmd, .sem_abort, .resp_valid, .resp,
      .mail_pending, .pins, .dq_in, .int_n, .busy_n);
   dpsem_ram_model u_ram (.pins, .sys_clk, .dq_in, .int_n, .int_r_n,
      .r_wr, .r_idx, .r_bit, .r_mail, .r_fetch, .stall_n(busy_n));
   task automatic final_report;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(string what, logic [17:0] seen, logic [17:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic run(dpsem_pkg::op_t op, logic [15:0] a, logic [17:0] d,
                      logic [1:0] be);
      int k;
      k = 0;
      @(negedge sys_clk);
      while (cmd_ready !== 1'b1) @(negedge sys_clk);
      cmd = '{op, a, d, be};
      cmd_valid = 1;
      @(negedge sys_clk);
      cmd_valid = 0;
      while (resp_valid !== 1'b1 && k < 2000) begin
         @(negedge sys_clk);
         k++;
      end
      check("answer", k < 2000, 1'b1);
   endtask
   task automatic rside(logic [2:0] i, logic b);
      @(negedge sys_clk);
      r_idx = i;
      r_bit = b;
      r_wr = 1;
      @(negedge sys_clk);
      r_wr = 0;
   endtask
   initial begin
      #30000;
      n_mismatch++;
      final_report;
   end
   initial begin
      repeat (3) @(negedge sys_clk);
      check("ce_n", pins.ce_n, 1'b1);
      check("ready", cmd_ready, 1'b1);
      rst_n = 1;
      foreach (rows[i]) begin
         run(rows[i].op, rows[i].a, rows[i].d, rows[i].be);
         if (rows[i].m != 0)
            check("rdata", resp.rdata & rows[i].m, rows[i].e);
         if (rows[i].op == dpsem_pkg::OP_SEM_TAKE)
            check("owned", resp.owned, 1'b1);
      end
      check("int_r", int_r_n, 1'b0);
      // Frozen mid-read: the pins must stand still and the read still land.
      fork
         run(dpsem_pkg::OP_READ, 16'h0003, 18'h0, 2'h3);
         begin
            repeat (4) @(negedge sys_clk);
            clk_en = 0;
            p = pins;
            repeat (20) @(negedge sys_clk);
            check("frozen", pins == p, 1'b1);
            clk_en = 1;
         end
      join
      check("rdata", resp.rdata, 18'h155CD);
      r_mail = 1;
      @(negedge sys_clk);
      r_mail = 0;
      repeat (2) @(negedge sys_clk);
      check("pending", mail_pending, 1'b1);
      run(dpsem_pkg::OP_READ, 16'hFFFF, 18'h0, 2'h3);
      check("mbox", resp.rdata, 18'h01234);
      check("int_l", int_n, 1'b0);
      check("int_r", int_r_n, 1'b0);
      run(dpsem_pkg::OP_MBX_FETCH, 16'h0000, 18'h0, 2'h3);
      repeat (2) @(negedge sys_clk);
      check("pending", mail_pending, 1'b0);
      // A stalled mailbox write must wait for the stall, not be lost.
      r_fetch = 1;
      busy_n = 0;
      @(negedge sys_clk);
      r_fetch = 0;
      fork
         run(dpsem_pkg::OP_MBX_SEND, 16'h0000, 18'h01234, 2'h3);
         begin
            repeat (15) @(negedge sys_clk);
            check("int_r", int_r_n, 1'b1);
            busy_n = 1;
         end
      join
      check("int_r", int_r_n, 1'b0);
      // A refused claim must withdraw its request, not pend forever.
      rside(3'd2, 1'b0);
      sem_abort = 1;
      run(dpsem_pkg::OP_SEM_TAKE, 16'h0002, 18'h0, 2'h3);
      sem_abort = 0;
      check("owned", resp.owned, 1'b0);
      rside(3'd2, 1'b1);
      run(dpsem_pkg::OP_SEM_PEEK, 16'h0002, 18'h0, 2'h3);
      check("free", resp.rdata, 18'h3FFFF);
      rside(3'd4, 1'b0);
      fork
         run(dpsem_pkg::OP_SEM_TAKE, 16'h0004, 18'h0, 2'h3);
         begin
            repeat (60) @(negedge sys_clk);
            rside(3'd4, 1'b1);
         end
      join
      check("handover", resp.owned, 1'b1);
      run(dpsem_pkg::OP_SEM_GIVE, 16'h0004, 18'h0, 2'h3);
      // Wired as the right port, the own mailbox is the top word.
      is_left_port = 0;
      run(dpsem_pkg::OP_MBX_FETCH, 16'h0000, 18'h0, 2'h3);
      check("fetch_r", resp.rdata, 18'h01234);
      final_report;
   end
endmodule
bind dpsem_host dpsem_host_checker u_chk (.sys_clk, .rst_n, .clk_en,
   .cmd_valid, .cmd_ready, .cmd, .resp_valid, .resp, .pins);
